/* File: ifl_top.v */
// ifl_top.v: interrupt field block, three leaf interrupt fields plus an aggregate register,
// with an APB slave for status, enables, halt enables and per-field configuration.
// assumes event pins are asynchronous to clk; one clock, synchronous active high reset.
//
// Overview of operation
// - each interrupt register drives the OR of its gated fields
// - per-register interrupt signal is an output port
// - absent holding choice, a field holds each bit separately
// - a held bit set to one stays until software clears it
// - per-bit holds bits independently; whole-field locks the value together
// - single-bit fields behave the same under either holding mode
// - level type sets the field whenever its input is asserted
// - a held level interrupt stays latched after its input drops
// - rising, falling and any-change types fire on matching input transitions
// - edges found by comparing input with its previous clocked value
// - pass-through field follows its trigger each cycle, no locking
// - pass-through combines with any trigger type
// - aggregate fields take lower register interrupt outputs directly as input
// - with enable attached, contribution is field AND enable
// - with mask attached, contribution is field AND inverted mask
// - halt output is field AND halt enable, or AND inverted halt mask
// - one of enable or mask, one halt reference, at field width
// - exactly one trigger type applies to each interrupt field
`include "ifl_regs.vh"

module ifl_top (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [`IFL_NF*`IFL_FW-1:0] evt_in,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire [`IFL_NF-1:0] reg_irq,
	output wire [`IFL_NF-1:0] reg_halt,
	output wire agg_irq,
	output wire irq
);
	wire [`IFL_NF*`IFL_FW-1:0] evt_s;
	reg [`IFL_NF*`IFL_FW-1:0] en_ff;
	reg [`IFL_NF*`IFL_FW-1:0] hen_ff;
	reg [`IFL_NF*8-1:0] cfg_ff;
	reg [`IFL_NF-1:0] agg_ff;
	reg [`IFL_NF-1:0] agg_mask_ff;
	wire [`IFL_NF*`IFL_FW-1:0] val;
	wire [`IFL_NF*`IFL_FW-1:0] hist;
	wire [`IFL_NF-1:0] fld_irq;
	wire [`IFL_NF-1:0] fld_halt;
	reg [`IFL_NF-1:0] clr;
	reg [`IFL_NF*`IFL_FW-1:0] clr_bits;

	// zero-wait slave: access phase completes in its first cycle
	wire acc = psel & penable & ce;
	wire wr = acc & pwrite;
	wire rd = acc & ~pwrite;
	wire mapped = (paddr[1:0] == 2'h0) && (paddr <= `IFL_OFF_HIST);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	ifl_sync #(.W(`IFL_NF*`IFL_FW)) u_sync (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.d(evt_in),
		.q(evt_s)
	);

	// clears: write-one-to-clear on status, or read when the field is clear-on-read
	integer k;
	always @* begin
		clr = {`IFL_NF{1'b0}};
		clr_bits = {`IFL_NF*`IFL_FW{1'b0}};
		for (k = 0; k < `IFL_NF; k = k + 1) begin
			if (mapped && paddr == (`IFL_OFF_STAT0 + k*4)) begin
				if (wr) begin
					clr[k] = 1'b1;
					clr_bits[k*`IFL_FW +: `IFL_FW] = pwdata[`IFL_FW-1:0];
				end else if (rd && cfg_ff[k*8+`IFL_CFG_RCLR]) begin
					clr[k] = 1'b1;
					clr_bits[k*`IFL_FW +: `IFL_FW] = {`IFL_FW{1'b1}};
				end
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < `IFL_NF; i = i + 1) begin : g_fld
			ifl_field u_fld (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.evt(evt_s[i*`IFL_FW +: `IFL_FW]),
				.cfg(cfg_ff[i*8 +: 8]),
				.gate(en_ff[i*`IFL_FW +: `IFL_FW]),
				.hgate(hen_ff[i*`IFL_FW +: `IFL_FW]),
				.sw_clr(clr[i]),
				.sw_clr_bits(clr_bits[i*`IFL_FW +: `IFL_FW]),
				.value(val[i*`IFL_FW +: `IFL_FW]),
				.hist(hist[i*`IFL_FW +: `IFL_FW]),
				.irq(fld_irq[i]),
				.halt(fld_halt[i])
			);
		end
	endgenerate

	assign reg_irq = fld_irq;
	assign reg_halt = fld_halt;

	// aggregate register: non-sticky level fields fed by leaf interrupt outputs
	always @(posedge clk) begin
		if (rst) begin
			agg_ff <= {`IFL_NF{1'b0}};
		end else if (ce) begin
			agg_ff <= fld_irq;
		end
	end
	assign agg_irq = |(agg_ff & ~agg_mask_ff);

	// one level output: any unmasked status bit of any register
	assign irq = (|fld_irq) | agg_irq;

	always @(posedge clk) begin
		if (rst) begin
			en_ff <= {`IFL_NF{`IFL_EN_RST}};
			hen_ff <= {`IFL_NF{`IFL_HEN_RST}};
			cfg_ff <= {`IFL_NF{`IFL_CFG_RST}};
			agg_mask_ff <= `IFL_AGG_MASK_RST;
		end else if (wr && mapped) begin
			case (paddr)
				`IFL_OFF_EN: en_ff <= pwdata[`IFL_NF*`IFL_FW-1:0];
				`IFL_OFF_HEN: hen_ff <= pwdata[`IFL_NF*`IFL_FW-1:0];
				`IFL_OFF_CFG: cfg_ff <= pwdata[`IFL_NF*8-1:0];
				`IFL_OFF_AGG_MASK: agg_mask_ff <= pwdata[`IFL_NF-1:0];
				default: ;
			endcase
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h00000000;
		end else if (ce && psel && !penable && !pwrite) begin
			case (paddr)
				`IFL_OFF_STAT0: prdata <= {24'h000000, val[`IFL_FW-1:0]};
				`IFL_OFF_STAT1: prdata <= {24'h000000, val[2*`IFL_FW-1:`IFL_FW]};
				`IFL_OFF_STAT2: prdata <= {24'h000000, val[3*`IFL_FW-1:2*`IFL_FW]};
				`IFL_OFF_EN: prdata <= {8'h00, en_ff};
				`IFL_OFF_HEN: prdata <= {8'h00, hen_ff};
				`IFL_OFF_CFG: prdata <= {8'h00, cfg_ff};
				`IFL_OFF_AGG: prdata <= {29'h00000000, agg_ff};
				`IFL_OFF_AGG_MASK: prdata <= {29'h00000000, agg_mask_ff};
				`IFL_OFF_HIST: prdata <= {8'h00, hist};
				default: prdata <= 32'h00000000;
			endcase
		end
	end
endmodule // ifl_top

/* File: ifl_regs.vh */
// ifl_regs.vh: register offsets, field positions, reset values and encodings for the
// interrupt field block.
// assumes inclusion by bare name from the design files of the same folder.
`ifndef IFL_REGS_VH
`define IFL_REGS_VH

`define IFL_FW 8
`define IFL_NF 3

`define IFL_OFF_STAT0 12'h000
`define IFL_OFF_STAT1 12'h004
`define IFL_OFF_STAT2 12'h008
`define IFL_OFF_EN 12'h00C
`define IFL_OFF_HEN 12'h010
`define IFL_OFF_CFG 12'h014
`define IFL_OFF_AGG 12'h018
`define IFL_OFF_AGG_MASK 12'h01C
`define IFL_OFF_HIST 12'h020

`define IFL_TRIG_LEVEL 2'h0
`define IFL_TRIG_POS 2'h1
`define IFL_TRIG_NEG 2'h2
`define IFL_TRIG_BOTH 2'h3

`define IFL_HOLD_BIT 2'h0
`define IFL_HOLD_FIELD 2'h1
`define IFL_HOLD_NONE 2'h2

// cfg byte per field: [1:0] trigger, [3:2] hold, [4] mask polarity, [5] halt mask polarity,
// [6] clear on read
`define IFL_CFG_TRIG_LSB 0
`define IFL_CFG_HOLD_LSB 2
`define IFL_CFG_MPOL 4
`define IFL_CFG_HPOL 5
`define IFL_CFG_RCLR 6
`define IFL_CFG_RST 8'h00

`define IFL_FIELD_RST 8'h00
`define IFL_HIST_RST 8'h00
`define IFL_EN_RST 8'hFF
`define IFL_HEN_RST 8'h00
`define IFL_AGG_MASK_RST 3'h0

`endif

/* File: ifl_field.v */
// ifl_field.v: one interrupt field with trigger detection, holding and gating.
// assumes evt is already synchronous to clk and cfg is stable between accesses.
`include "ifl_regs.vh"

module ifl_field (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [`IFL_FW-1:0] evt,
	input wire [7:0] cfg,
	input wire [`IFL_FW-1:0] gate,
	input wire [`IFL_FW-1:0] hgate,
	input wire sw_clr,
	input wire [`IFL_FW-1:0] sw_clr_bits,
	output wire [`IFL_FW-1:0] value,
	output wire [`IFL_FW-1:0] hist,
	output wire irq,
	output wire halt
);
	reg [`IFL_FW-1:0] val_ff;
	reg [`IFL_FW-1:0] hist_ff;
	reg [`IFL_FW-1:0] nxt_val;
	reg [`IFL_FW-1:0] trig;
	wire [1:0] trig_mode = cfg[`IFL_CFG_TRIG_LSB+1:`IFL_CFG_TRIG_LSB];
	wire [1:0] hold_mode = cfg[`IFL_CFG_HOLD_LSB+1:`IFL_CFG_HOLD_LSB];
	wire [`IFL_FW-1:0] keep = val_ff & ~sw_clr_bits;

	always @* begin
		case (trig_mode)
			`IFL_TRIG_POS: trig = evt & ~hist_ff;
			`IFL_TRIG_NEG: trig = ~evt & hist_ff;
			`IFL_TRIG_BOTH: trig = evt ^ hist_ff;
			default: trig = evt;
		endcase
	end

	always @* begin
		case (hold_mode)
			// a fresh event beats a clear that empties the field in the same cycle
			`IFL_HOLD_FIELD: nxt_val = (sw_clr && (keep == {`IFL_FW{1'b0}})) ?
				trig : ((val_ff != {`IFL_FW{1'b0}}) ? keep : trig);
			`IFL_HOLD_NONE: nxt_val = trig;
			default: nxt_val = keep | trig;
		endcase
	end

	always @(posedge clk) begin
		if (rst) begin
			val_ff <= `IFL_FIELD_RST;
			hist_ff <= `IFL_HIST_RST;
		end else if (ce) begin
			val_ff <= nxt_val;
			hist_ff <= evt;
		end
	end

	wire [`IFL_FW-1:0] g = cfg[`IFL_CFG_MPOL] ? ~gate : gate;
	wire [`IFL_FW-1:0] hg = cfg[`IFL_CFG_HPOL] ? ~hgate : hgate;
	assign irq = |(val_ff & g);
	assign halt = |(val_ff & hg);
	assign value = val_ff;
	assign hist = hist_ff;
endmodule // ifl_field

/* File: ifl_sync.v */
// ifl_sync.v: two-flop synchroniser for a bus of event inputs.
// assumes the inputs are quasi-static relative to clk; bits are not coherent.
module ifl_sync #(
	parameter W = 8
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] s1_ff;
	reg [W-1:0] s2_ff;
	always @(posedge clk) begin
		if (rst) begin
			s1_ff <= {W{1'b0}};
			s2_ff <= {W{1'b0}};
		end else if (ce) begin
			s1_ff <= d;
			s2_ff <= s1_ff;
		end
	end
	assign q = s2_ff;
endmodule // ifl_sync

/* File: ifl_src.sv */
// ifl_src.sv: event sources on the hardware side of the block.
// assumes the bench names the wanted level of each event line.
module ifl_src (
	input wire logic clk,
	input wire logic [23:0] want,
	output logic [23:0] evt
);
	initial evt = 24'h000000;
	// lines move just after an edge, as registered source logic would
	always @(posedge clk) evt <= want;
endmodule // ifl_src

/* File: ifl_monitor.sv */
// ifl_monitor.sv: port checker for ifl_top.
// assumes one clock and the synchronous active high reset.
module ifl_monitor (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [2:0] reg_irq,
	input wire [2:0] reg_halt,
	input wire agg_irq,
	input wire irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_or; irq == (|reg_irq || agg_irq); endproperty
	a_or: assert property (p_or) else $error("irq bad");
	property p_agg; agg_irq && $past(ce) |-> $past(reg_irq) != 3'h0; endproperty
	a_agg: assert property (p_agg) else $error("agg bad");
	property p_rst; $fell(rst) |-> (!irq && reg_halt == 3'h0) [*2]; endproperty
	a_rst: assert property (p_rst) else $error("spurious after reset");
	// fields 0 and 1 never run pass-through in the bench
	property p_hold; !psel && ce |=> !$fell(reg_irq[0]) && !$fell(reg_irq[1]); endproperty
	a_hold: assert property (p_hold) else $error("held bit lost");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("pslverr outside access");
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_prd; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_prd: assert property (p_prd) else $error("prdata moved");
	property p_unm; psel && penable && !pwrite && pslverr |-> prdata == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
endmodule // ifl_monitor

bind ifl_top ifl_monitor u_mon (.clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reg_irq(reg_irq),
	.reg_halt(reg_halt), .agg_irq(agg_irq), .irq(irq));

/* File: tb_top.sv */
// tb_top.sv: self-checking bench for the interrupt field block over APB.
// assumes ifl_src drives the event pins and the monitor is bound to ifl_top.
`include "ifl_regs.vh"

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0, err;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q;
	logic [23:0] want = 0, evt_in;
	logic pready, pslverr, agg_irq, irq;
	logic [2:0] reg_irq, reg_halt;
	int mismatches = 0, samples_checked = 0, r, t, st0;

	ifl_top u_dut (.clk(clk), .rst(rst), .ce(ce), .evt_in(evt_in), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .reg_irq(reg_irq), .reg_halt(reg_halt),
		.agg_irq(agg_irq), .irq(irq));
	ifl_src u_src (.clk(clk), .want(want), .evt(evt_in));

	initial forever #12.5 clk = ~clk;

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		#1;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 32'h0);
		chk(q, e);
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task report_and_stop;
		$display("mismatches=%0d checks=%0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		#50us;
		mismatches++;
		report_and_stop;
	end

	initial begin
		void'($urandom(32'h33BD));
		repeat (2) @(posedge clk);
		rst <= 0;
		#1;
		chk(irq, 0);
		rd(`IFL_OFF_EN, 32'hFFFFFF);
		rd(`IFL_OFF_HEN, 32'h0);
		r = $urandom % 255 + 1;
		want <= 24'(r);
		wt(5);
		want <= 0;
		wt(5);
		rd(`IFL_OFF_STAT0, r);
		chk(reg_irq, 32'h1);
		t = $urandom % 256;
		apb(1, `IFL_OFF_STAT0, t);
		st0 = r & ~t;
		rd(`IFL_OFF_STAT0, st0);
		apb(1, `IFL_OFF_STAT0, 32'hFF);
		want <= 24'h1;
		wt(5);
		apb(1, `IFL_OFF_EN, 32'hFFFF00);
		chk(reg_irq[0], 0);
		apb(1, `IFL_OFF_CFG, 32'h10);
		chk(reg_irq[0], 1);
		apb(1, `IFL_OFF_HEN, 32'h1);
		chk(reg_halt[0], 1);
		want <= 0;
		wt(5);
		apb(1, `IFL_OFF_STAT0, 32'hFF);
		for (t = 1; t < 4; t++) begin
			apb(1, `IFL_OFF_CFG, 32'(t) << 8);
			apb(1, `IFL_OFF_STAT1, 32'hFF);
			want <= 24'h100;
			wt(5);
			chk(reg_irq[1], t != 2);
			apb(1, `IFL_OFF_STAT1, 32'hFF);
			want <= 0;
			wt(5);
			chk(reg_irq[1], t > 1);
		end
		apb(1, `IFL_OFF_CFG, 32'h400);
		apb(1, `IFL_OFF_STAT1, 32'hFF);
		want <= 24'h300;
		wt(5);
		want <= 24'hC00;
		wt(5);
		rd(`IFL_OFF_STAT1, 32'h3);
		apb(1, `IFL_OFF_CFG, 32'h80000);
		want <= 24'h5A0000;
		wt(5);
		rd(`IFL_OFF_STAT2, 32'h5A);
		rd(`IFL_OFF_AGG, 32'h6);
		chk(agg_irq, 1);
		want <= 0;
		wt(5);
		rd(`IFL_OFF_STAT2, 32'h0);
		// clock enable low must freeze the synchroniser and the field
		apb(1, `IFL_OFF_STAT1, 32'hFF);
		ce <= 0;
		want <= 24'h100;
		wt(6);
		chk(reg_irq[1], 0);
		ce <= 1;
		wt(5);
		chk(reg_irq[1], 1);
		rd(`IFL_OFF_HIST, 32'h100);
		apb(1, `IFL_OFF_AGG_MASK, 32'h7);
		chk(agg_irq, 0);
		want <= 0;
		wt(5);
		// field 1: clear on read plus inverted halt reference
		apb(1, `IFL_OFF_CFG, 32'h6000);
		chk(reg_halt[1], 1);
		rd(`IFL_OFF_STAT1, 32'h1);
		rd(`IFL_OFF_STAT1, 32'h0);
		chk(reg_halt[1], 0);
		apb(0, 12'h03C, 32'h0);
		chk(q, 32'h0);
		chk(err, 1);
		report_and_stop;
	end
endmodule // tb_top
